// [rtl/asp_pkg.sv]
package asp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int          CLK_PERIOD_NS  = 5;
   localparam int          WAKE_DELAY_NS  = 1000;
   localparam int          QUIET_NS       = 30;
   localparam logic [7:0]  WAKE_CYC       = 8'((WAKE_DELAY_NS + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS);
   localparam logic [7:0]  QUIET_CYC      = 8'((QUIET_NS + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS);
   localparam logic [2:0]  SCLK_HALF_CYC  = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // frame edge counts
   localparam logic [4:0]  EDGES_GLITCH   = 5'h02;
   localparam logic [4:0]  EDGES_AWAKE    = 5'h0A;
   localparam logic [4:0]  EDGES_PD       = 5'h04;
   localparam logic [4:0]  EDGES_LONG     = 5'h10;
   localparam logic [4:0]  EDGES_SHORT    = 5'h0E;
   localparam logic [4:0]  LEAD_ZEROS     = 5'h02;
   localparam int          RES_W          = 12;
   localparam int          FRAME_W        = 16;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      OP_CONVERT,
      OP_PARTIAL,
      OP_FULL,
      OP_WAKE
   } asp_op_t;

   typedef enum logic [1:0] {
      PS_UNKNOWN,
      PS_NORMAL,
      PS_PARTIAL,
      PS_FULL
   } asp_pwr_t;

   typedef enum logic [1:0] {
      ACT_DONE,
      ACT_DUMMY,
      ACT_SHORT,
      ACT_CONV
   } asp_act_t;

   typedef struct packed {
      asp_op_t op;
      logic    len16;
      logic    res12;
   } asp_cmd_t;

endpackage

// [rtl/asp_sclk_gen.sv]
`timescale 1ns/1ps
module asp_sclk_gen (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // control
   input  wire logic run,
   // serial clock
   output logic      sclk,
   output logic      fall_p,
   output logic      rise_p
);
   import asp_pkg::*;

   logic [2:0] cnt_ff;
   logic       sclk_ff;
   logic       wrap;

   // divider wrap point
   assign wrap   = run && (cnt_ff == SCLK_HALF_CYC - 3'h1);
   assign fall_p = wrap && sclk_ff;
   assign rise_p = wrap && !sclk_ff;
   assign sclk   = sclk_ff;

   // half-period counter, idles high while stopped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_ff  <= 3'h0;
         sclk_ff <= 1'b1;
      end else if (ce) begin
         if (!run) begin
            cnt_ff  <= 3'h0;
            sclk_ff <= 1'b1;
         end else if (wrap) begin
            cnt_ff  <= 3'h0;
            sclk_ff <= !sclk_ff;
         end else begin
            cnt_ff  <= cnt_ff + 3'h1;
         end
      end
   end

endmodule // asp_sclk_gen

// [rtl/asp_rx_shift.sv]
`timescale 1ns/1ps
module asp_rx_shift (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          ce,
   // serial input from pin
   input  wire logic                          serial_result_out,
   // control
   input  wire logic                          clr,
   input  wire logic                          smp,
   // captured bits, first bit highest
   output logic [asp_pkg::FRAME_W-1:0]        bits
);
   import asp_pkg::*;

   logic                 sync1_ff;
   logic                 sync2_ff;
   logic [FRAME_W-1:0]   shift_ff;

   // two-flop synchroniser for the pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else if (ce) begin
         sync1_ff <= serial_result_out;
         sync2_ff <= sync1_ff;
      end
   end

   // msb-first shift on each sample strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shift_ff <= '0;
      end else if (ce) begin
         if (clr) begin
            shift_ff <= '0;
         end else if (smp) begin
            shift_ff <= {shift_ff[FRAME_W-2:0], sync2_ff};
         end
      end
   end

   assign bits = shift_ff;

endmodule // asp_rx_shift

// [rtl/asp_host.sv]
`timescale 1ns/1ps
module asp_host (
   // system
   input  wire logic              CLK_SYS,
   input  wire logic              RESET_N,
   input  wire logic              CE,
   // command port
   input  wire logic              CMD_VALID,
   output logic                   CMD_READY,
   input  wire asp_pkg::asp_cmd_t CMD,
   // result port
   output logic                   RSLT_VALID,
   output logic [11:0]            RSLT_DATA,
   output asp_pkg::asp_pwr_t      PWR_STATE,
   output logic                   BUSY,
   // converter pins
   output logic                   CONV_SEL_N,
   output logic                   SCLK,
   input  wire logic              SERIAL_RESULT_OUT
);
   import asp_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CLOCK,
      ST_QUIET
   } asp_st_t;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   asp_st_t             st_ff;
   asp_pwr_t            pwr_ff;
   asp_op_t             goal_ff;
   asp_act_t            act_ff;
   asp_act_t            nxt_act;
   logic                active_ff;
   logic                len16_ff;
   logic                res12_ff;
   logic                cs_n_ff;
   logic [4:0]          edge_ff;
   logic [4:0]          target_ff;
   logic [7:0]          quiet_ff;
   logic [7:0]          wake_ff;
   logic                wake_act_ff;
   logic                conv_done_ff;
   logic                rslt_valid_ff;
   logic [11:0]         rslt_ff;
   logic                fall_p;
   logic                rise_p;
   logic                run;
   logic                frame_end;
   logic                frame_go;
   logic                wake_wait;
   logic [FRAME_W-1:0]  bits;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // pick the next frame toward the goal from the believed power state
   function automatic asp_act_t plan(input asp_op_t g, input asp_pwr_t p, input logic cd);
      asp_act_t a;
      a = ACT_DUMMY;
      unique case (g)
         OP_CONVERT: a = cd ? ACT_DONE : ((p == PS_NORMAL) ? ACT_CONV : ACT_DUMMY);
         OP_WAKE:    a = (p == PS_NORMAL) ? ACT_DONE : ACT_DUMMY;
         OP_PARTIAL: a = (p == PS_PARTIAL) ? ACT_DONE
                       : ((p == PS_NORMAL) ? ACT_SHORT : ACT_DUMMY);
         OP_FULL:    a = (p == PS_FULL) ? ACT_DONE
                       : ((p == PS_UNKNOWN) ? ACT_DUMMY : ACT_SHORT);
      endcase
      return a;
   endfunction

   // pull the result out of the captured frame, right-justified
   function automatic logic [11:0] extract(input logic [FRAME_W-1:0] b, input logic l16,
                                           input logic r12);
      logic [11:0] w;
      w = l16 ? b[13:2] : b[11:0];
      return r12 ? w : {2'h0, w[11:2]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // sub-blocks
   assign run = (st_ff == ST_CLOCK);

   asp_sclk_gen u_sclk (
      .clk    (CLK_SYS),
      .rst_n  (RESET_N),
      .ce     (CE),
      .run    (run),
      .sclk   (SCLK),
      .fall_p (fall_p),
      .rise_p (rise_p)
   );

   asp_rx_shift u_rx (
      .clk    (CLK_SYS),
      .rst_n  (RESET_N),
      .ce     (CE),
      .serial_result_out  (SERIAL_RESULT_OUT),
      .clr    (frame_go),
      .smp    (fall_p && run),                    // capture at falls only
      .bits   (bits)
   );

   ////////////////////////////////////////////////////////////////////////////
   // handshake and frame control terms
   assign nxt_act   = plan(goal_ff, pwr_ff, conv_done_ff);
   assign CMD_READY = (st_ff == ST_IDLE) && !active_ff;
   assign frame_go  = (st_ff == ST_IDLE) && active_ff && (nxt_act != ACT_DONE);
   // select rises only on the rise that follows the target fall
   assign frame_end = run && rise_p && (edge_ff == target_ff);
   assign wake_wait = wake_act_ff && (wake_ff < WAKE_CYC);

   // command capture and completion
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         active_ff <= 1'b0;
         goal_ff   <= OP_WAKE;
         len16_ff  <= 1'b1;
         res12_ff  <= 1'b1;
      end else if (CE) begin
         if (CMD_VALID && CMD_READY) begin
            active_ff <= 1'b1;
            goal_ff   <= CMD.op;
            len16_ff  <= CMD.len16;
            res12_ff  <= CMD.res12;
         end else if ((st_ff == ST_IDLE) && active_ff && (nxt_act == ACT_DONE)) begin
            active_ff <= 1'b0;
         end
      end
   end

   // frame sequencer
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         st_ff     <= ST_IDLE;
         cs_n_ff   <= 1'b1;
         act_ff    <= ACT_DONE;
         target_ff <= EDGES_LONG;
         quiet_ff  <= 8'h00;
      end else if (CE) begin
         unique case (st_ff)
            ST_IDLE: begin
               if (frame_go) begin
                  st_ff   <= ST_CLOCK;
                  cs_n_ff <= 1'b0;
                  act_ff  <= nxt_act;
                  // dummy frames run long so the device wakes fully
                  if (nxt_act == ACT_SHORT) begin
                     target_ff <= EDGES_PD;
                  end else if (nxt_act == ACT_CONV && !len16_ff) begin
                     target_ff <= EDGES_SHORT;
                  end else begin
                     target_ff <= EDGES_LONG;
                  end
               end
            end
            ST_CLOCK: begin
               if (frame_end) begin
                  st_ff    <= ST_QUIET;
                  cs_n_ff  <= 1'b1;
                  quiet_ff <= 8'h00;
               end
            end
            ST_QUIET: begin
               if (quiet_ff < QUIET_CYC) begin
                  quiet_ff <= quiet_ff + 8'h01;
               end else if (!wake_wait) begin
                  st_ff <= ST_IDLE;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // falling edges counted from select fall
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         edge_ff <= 5'h00;
      end else if (CE) begin
         if (frame_go) begin
            edge_ff <= 5'h00;
         end else if (run && fall_p) begin
            edge_ff <= edge_ff + 5'h01;
         end
      end
   end

   // wake delay timed from the select fall of a frame leaving full power-down
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         wake_act_ff <= 1'b0;
         wake_ff     <= 8'h00;
      end else if (CE) begin
         if (frame_go) begin
            // an unknown state may be full power-down, so wait then too
            wake_act_ff <= (pwr_ff == PS_FULL) || (pwr_ff == PS_UNKNOWN);
            wake_ff     <= 8'h00;
         end else if (wake_act_ff && wake_ff < WAKE_CYC) begin
            wake_ff <= wake_ff + 8'h01;
         end
      end
   end

   // believed power state of the converter, updated at select rise
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         pwr_ff <= PS_UNKNOWN;
      end else if (CE && frame_end) begin
         if (edge_ff >= EDGES_AWAKE) begin
            pwr_ff <= PS_NORMAL;
         end else if (pwr_ff == PS_NORMAL && edge_ff >= EDGES_GLITCH) begin
            pwr_ff <= PS_PARTIAL;
         end else if (pwr_ff == PS_PARTIAL || pwr_ff == PS_FULL) begin
            pwr_ff <= PS_FULL;
         end
      end
   end

   // result capture after a conversion frame
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         rslt_valid_ff <= 1'b0;
         rslt_ff       <= 12'h000;
         conv_done_ff  <= 1'b0;
      end else if (CE) begin
         rslt_valid_ff <= 1'b0;
         if (CMD_VALID && CMD_READY) begin
            conv_done_ff <= 1'b0;
         end else if (frame_end && act_ff == ACT_CONV) begin
            rslt_valid_ff <= 1'b1;
            rslt_ff       <= extract(bits, len16_ff, res12_ff);
            conv_done_ff  <= 1'b1;
         end
      end
   end

   assign RSLT_VALID = rslt_valid_ff;
   assign RSLT_DATA  = rslt_ff;
   assign PWR_STATE  = pwr_ff;
   assign BUSY       = active_ff || (st_ff != ST_IDLE);
   assign CONV_SEL_N = cs_n_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [7:0] hi_cnt_ff;
   logic       seen_dummy_ff;

   // cycles since select went high, and whether a long frame ran yet
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         hi_cnt_ff     <= 8'hFF;  // saturated: no frame precedes the first one
         seen_dummy_ff <= 1'b0;
      end else if (CE) begin
         if (!cs_n_ff) begin
            hi_cnt_ff <= 8'h00;
         end else if (hi_cnt_ff != 8'hFF) begin
            hi_cnt_ff <= hi_cnt_ff + 8'h01;
         end
         if (frame_end && edge_ff >= EDGES_AWAKE) begin
            seen_dummy_ff <= 1'b1;
         end
      end
   end

   AST_QUIET_GAP: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CE)
      $fell(cs_n_ff) |-> $past(hi_cnt_ff) >= QUIET_CYC)
      else $error("select fell before quiet time");

   AST_WAKE_WAIT: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CE)
      $fell(cs_n_ff) && $past(wake_act_ff) |-> $past(wake_ff) >= WAKE_CYC)
      else $error("frame started inside wake delay");

   AST_DUMMY_FIRST: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CE)
      RSLT_VALID |-> seen_dummy_ff)
      else $error("result without prior full frame");

   AST_PD_WINDOW: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CE)
      frame_end && act_ff == ACT_SHORT |-> edge_ff >= EDGES_GLITCH && edge_ff < EDGES_AWAKE)
      else $error("power-down frame outside edge window");

   AST_FULL_LEN: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CE)
      frame_end && act_ff == ACT_CONV |-> edge_ff == (len16_ff ? EDGES_LONG : EDGES_SHORT))
      else $error("conversion frame has wrong edge count");

   AST_DUMMY_WAKES: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CE)
      frame_end && act_ff == ACT_DUMMY |=> pwr_ff == PS_NORMAL)
      else $error("dummy frame did not wake converter");

   AST_FULL_FROM_PARTIAL: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N || !CE) $changed(pwr_ff) && pwr_ff == PS_FULL |-> $past(pwr_ff) == PS_PARTIAL)
      else $error("full power-down not reached through partial");

   AST_EDGES_IN_FRAME: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N || !CE) $rose(cs_n_ff) |-> $past(edge_ff) == $past(target_ff) && SCLK)
      else $error("select rose at wrong edge count");

   AST_RESULT_PULSE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CE)
      frame_end && act_ff == ACT_CONV |=> RSLT_VALID ##1 !RSLT_VALID)
      else $error("result pulse not one cycle");

   COV_CONVERT: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) RSLT_VALID);
   COV_PARTIAL: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
      $changed(pwr_ff) && pwr_ff == PS_PARTIAL);
   COV_FULL:    cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
      $changed(pwr_ff) && pwr_ff == PS_FULL);
   COV_WAKE:    cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
      wake_act_ff && wake_ff == WAKE_CYC);

endmodule // asp_host

// [verif/asp_dev_model.sv]
`timescale 1ns/1ps
module asp_dev_model (
   // converter pins
   input  wire logic         sel_n,
   input  wire logic         sclk,
   output logic              sdo,
   // bench side
   input  wire logic [11:0]  sample,
   input  wire logic         res12,
   output asp_pkg::asp_pwr_t pwr,
   output int                frames,
   output int                errs
);
   import asp_pkg::*;

   logic [15:0] frame;
   logic        ok;
   logic        in_frame;
   int          cnt;
   realtime     t_rise;
   realtime     t_wake;

   // power state after supply-up is not known to the host
   initial begin
      sdo      = 1'b1;
      pwr      = PS_PARTIAL;
      frames   = 0;
      errs     = 0;
      cnt      = 0;
      in_frame = 1'b0;
      t_rise   = 0;
      t_wake   = -1.0e6;
   end

   ////////////////////////////////////////////////////////////////////////////
   // select fall: latch sample, leave three-state with first zero
   always @(negedge sel_n) if (sel_n === 1'b0) begin
      if ($realtime - t_rise < QUIET_NS) errs++;
      // a frame started before wake-up completes converts garbage
      ok = (pwr == PS_NORMAL) && ($realtime - t_wake >= WAKE_DELAY_NS);
      if (pwr == PS_FULL) t_wake = $realtime;
      frame = res12 ? {2'h0, sample, 2'h0} : {2'h0, sample[9:0], 4'h0};
      if (!ok) frame[13:2] = ~frame[13:2];
      cnt      = 0;
      in_frame = 1'b1;
      frames++;
      sdo = 1'b0;
   end

   // each clock fall shifts the next bit, release after sixteenth
   always @(negedge sclk) if (sel_n === 1'b0 && in_frame) begin
      cnt++;
      if (cnt < 16) sdo = frame[15-cnt];
      else if (cnt == 16) sdo = ~sdo;
   end

   // select rise: abort, release line, decide power state
   always @(posedge sel_n) if (in_frame) begin
      in_frame = 1'b0;
      t_rise   = $realtime;
      if (cnt < 16) sdo = ~sdo;
      if (cnt >= 10 && cnt < (res12 ? 14 : 12)) errs++;
      if (cnt >= 10) pwr = PS_NORMAL;
      else if (pwr != PS_NORMAL) pwr = PS_FULL;
      else if (cnt >= 2) pwr = PS_PARTIAL;
   end
endmodule  // asp_dev_model

// [verif/adc_serial_power_control_tb.sv]
`timescale 1ns/1ps
module adc_serial_power_control_tb;
   import asp_pkg::*;

   logic        CLK_SYS = 1'b0;
   logic        RESET_N;
   logic        CE;
   logic        CMD_VALID;
   logic        CMD_READY;
   asp_cmd_t    cmd;
   logic        RSLT_VALID;
   logic [11:0] RSLT_DATA;
   asp_pwr_t    PWR_STATE;
   logic        BUSY;
   logic        CONV_SEL_N;
   logic        SCLK;
   logic        sdo;
   logic [11:0] sample;
   logic        jitter;
   asp_pwr_t    dev_pwr;
   asp_pwr_t    cur;
   int          frames;
   int          errs;
   int          bad_count;
   int          checked;
   asp_op_t     ops [10];

   // system clock
   always #2.5 CLK_SYS = ~CLK_SYS;

   asp_host DUT (
      .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .CE(CE),
      .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(cmd),
      .RSLT_VALID(RSLT_VALID), .RSLT_DATA(RSLT_DATA), .PWR_STATE(PWR_STATE),
      .BUSY(BUSY), .CONV_SEL_N(CONV_SEL_N), .SCLK(SCLK), .SERIAL_RESULT_OUT(sdo)
   );

   asp_dev_model dev (
      .sel_n(CONV_SEL_N), .sclk(SCLK), .sdo(sdo), .sample(sample),
      .res12(cmd.res12), .pwr(dev_pwr), .frames(frames), .errs(errs)
   );

   ////////////////////////////////////////////////////////////////////////////
   // frames a command needs from a given belief of state
   function automatic int exp_frames(asp_pwr_t s, asp_op_t op);
      case (op)
         OP_CONVERT: return (s == PS_NORMAL) ? 1 : 2;
         OP_WAKE:    return (s == PS_NORMAL) ? 0 : 1;
         OP_PARTIAL: return (s == PS_PARTIAL) ? 0 : (s == PS_NORMAL) ? 1 : 2;
         default:    return (s == PS_FULL) ? 0 : (s == PS_PARTIAL) ? 1 :
                            (s == PS_NORMAL) ? 2 : 3;
      endcase
   endfunction

   // state a command leaves behind
   function automatic asp_pwr_t goal(asp_op_t op);
      return (op == OP_PARTIAL) ? PS_PARTIAL : (op == OP_FULL) ? PS_FULL : PS_NORMAL;
   endfunction

   task check(input logic ok, input string what);
      checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   task finish_test;
      $display("checks %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // one clock, optionally stalling the design by its enable
   task tick;
      @(negedge CLK_SYS);
      CE = jitter ? ($urandom_range(3) != 0) : 1'b1;
   endtask

   // issue one command and check frames, state and result
   task run(input asp_op_t op, input logic len16, input logic r12);
      int          n;
      int          rv;
      int          f0;
      asp_pwr_t    g;
      logic [11:0] exp;
      logic        ce_used;
      logic        pv;
      tick;
      sample    = 12'($urandom);
      cmd       = '{op, len16, r12};
      CMD_VALID = 1'b1;
      f0        = frames;
      g         = goal(op);
      exp       = r12 ? sample : {2'h0, sample[9:0]};
      n         = 0;
      rv        = 0;
      pv        = 1'b0;
      while (!(CMD_READY === 1'b1 && CE === 1'b1) && n < 100) begin
         tick;
         n++;
      end
      check(n < 100, "command not taken");
      tick;
      CMD_VALID = 1'b0;
      n = 0;
      while (BUSY !== 1'b0 && n < 8000) begin
         ce_used = CE;
         tick;
         n++;
         // a pulse held by a low enable is one result, not two
         if (RSLT_VALID === 1'b1 && (!pv || ce_used)) begin
            rv++;
            check(RSLT_DATA === exp, "result data");
         end
         pv = (RSLT_VALID === 1'b1);
      end
      check(n < 8000, "command never finished");
      check(rv == (op == OP_CONVERT), "result count");
      check(frames - f0 == exp_frames(cur, op), "frame count");
      check(dev_pwr === g, "device state");
      check(PWR_STATE === g, "host state");
      cur = g;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(17));
      RESET_N   = 1'b0;
      CE        = 1'b1;
      CMD_VALID = 1'b0;
      cmd       = '0;
      sample    = 12'h000;
      jitter    = 1'b0;
      cur       = PS_UNKNOWN;
      bad_count = 0;
      checked   = 0;
      ops = '{OP_FULL, OP_CONVERT, OP_PARTIAL, OP_PARTIAL, OP_FULL,
              OP_WAKE, OP_FULL, OP_PARTIAL, OP_CONVERT, OP_FULL};
      repeat (5) @(negedge CLK_SYS);
      RESET_N = 1'b1;
      check(PWR_STATE === PS_UNKNOWN && CONV_SEL_N === 1'b1, "reset state");
      check(SCLK === 1'b1 && CMD_READY === 1'b1 && BUSY === 1'b0, "reset idle");
      foreach (ops[i]) run(ops[i], i[0], i[1]);
      // reset in mid-run while the converter sits in full power-down
      RESET_N = 1'b0;
      repeat (5) @(negedge CLK_SYS);
      RESET_N = 1'b1;
      cur     = PS_UNKNOWN;
      check(PWR_STATE === PS_UNKNOWN && BUSY === 1'b0, "reset in mid-run");
      // random conversions, the first one waking from full power-down
      jitter = 1'b1;
      repeat (16) run(OP_CONVERT, 1'($urandom), 1'($urandom));
      jitter = 1'b0;
      check(errs == 0, "device protocol errors");
      finish_test;
   end

   // watchdog against a hung handshake
   initial begin
      #400000;
      bad_count++;
      finish_test;
   end
endmodule  // adc_serial_power_control_tb
